// ---- bench/digital_input_function_mapper_test.sv ----
`timescale 1ns/1ps
`include "dim_consts.vh"
module digital_input_function_mapper_test;
reg clk = 1'b0;
reg rstn = 1'b0;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [7:0] paddr = 8'h00;
reg [31:0] pwdata = 32'h0;
reg [5:0] press = 6'h00;
reg [5:0] nc_wired = 6'h00;
wire [5:0] input_terminals_all;
wire [31:0] prdata;
wire pready, pslverr, irq, program_pause, local_remote_changeover, analog_setpoint_second;
wire alternate_parameter_set, manual_mode, fieldbus_control;
wire start_enable, forward_rotation, reverse_rotation;
wire [15:0] general_status_word, counter_display_value;
wire [2:0] output_relay;
wire [6:0] fn = {program_pause, local_remote_changeover, analog_setpoint_second,
    alternate_parameter_set, manual_mode, fieldbus_control, general_status_word[11]};
integer bad_count = 0;
integer checks = 0;
integer k;
dim_top dim_top_inst (.clk, .rstn, .input_terminals_all, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .program_pause, .local_remote_changeover,
    .analog_setpoint_second, .alternate_parameter_set, .manual_mode, .fieldbus_control,
    .general_status_word, .start_enable, .forward_rotation, .reverse_rotation, .output_relay,
    .counter_display_value);
dim_switches dim_switches_inst (.clk, .press, .nc_wired, .contact(input_terminals_all));
initial forever #4 clk = ~clk;
////////////////////////////////////////////////////////////////
task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// answer taken at the rising edge that sees pready high; only the watchdog ends a wait
task apb(input w, input [7:0] a, input [31:0] d, input [31:0] exp, input e_exp);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
        @(posedge clk);
    end
    if (!w)
        chk(prdata, exp);
    chk({pready, pslverr}, {1'b1, e_exp});
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
endtask
task rd(input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0, exp, 1'b0);
endtask
task hold(input [5:0] m, input integer n);
    @(posedge clk);
    press <= m;
    repeat (n) @(posedge clk);
    @(negedge clk);
endtask
////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(`DIM_OFS_POL, 32'h0);
    rd(`DIM_OFS_ASSIGN, 32'h0);
    rd(`DIM_OFS_CMP1, 32'h0);
    rd(`DIM_OFS_CMP2, 32'h0);
    apb(1'b0, 8'h2c, 32'h0, 32'h0, 1'b1);
    hold(6'h3f, 4);
    chk(fn, 7'h02);
    chk(counter_display_value, 16'h0);
    hold(6'h00, 4);
    wr(`DIM_OFS_ASSIGN, {8'h0, 3'd2, 3'd1, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1});
    for (k = 0; k < 6; k = k + 1) begin
        hold(6'h01 << k, 4);
        chk(fn, {k == 0, k == 3, k == 4, k == 5, k == 1, k != 1, k == 0});
    end
    @(posedge clk);
    nc_wired <= 6'h01;
    wr(`DIM_OFS_POL, 32'h1);
    hold(6'h00, 4);
    chk(fn, 7'h02);
    hold(6'h01, 4);
    chk(fn, 7'h43);
    @(posedge clk);
    nc_wired <= 6'h00;
    wr(`DIM_OFS_POL, 32'h0);
    wr(`DIM_OFS_CMP1, 32'h3);
    wr(`DIM_OFS_CMP2, 32'h5);
    wr(`DIM_OFS_OUTSEL, {17'h0, 5'h14, 5'h15, 5'h14});
    wr(`DIM_OFS_IRQ_MASK, 32'h1);
    hold(6'h04, 4);
    hold(6'h00, 6);
    for (k = 0; k < 5; k = k + 1) begin
        hold(6'h02, 6);
        hold(6'h00, 6);
        if (k == 2) begin
            chk(counter_display_value, 16'h3);
            chk(output_relay, 3'b101);
            chk(irq, 1'b1);
        end
    end
    chk(output_relay, 3'b111);
    rd(`DIM_OFS_COUNT, 32'h5);
    wr(`DIM_OFS_IRQ_STAT, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(`DIM_OFS_IRQ_STAT, 32'he);
    hold(6'h04, 6);
    chk({output_relay, counter_display_value}, 19'h0);
    hold(6'h00, 4);
    wr(`DIM_OFS_CTRL, {29'h0, `DIM_SS_FWD_REV});
    hold(6'h01, 4);
    chk({start_enable, forward_rotation, reverse_rotation}, 3'b110);
    rd(`DIM_OFS_FUNC, 32'h000101d1);
    rd(`DIM_OFS_GSW, 32'h00000800);
    hold(6'h03, 4);
    chk({start_enable, forward_rotation, reverse_rotation}, 3'b101);
    hold(6'h02, 4);
    chk({start_enable, forward_rotation, reverse_rotation}, 3'b000);
    hold(6'h00, 4);
    chk({start_enable, forward_rotation, reverse_rotation}, 3'b000);
    final_report;
end
// the whole sequence takes well under a thousand cycles
initial begin
    #40000;
    bad_count = bad_count + 1;
    final_report;
end
endmodule // digital_input_function_mapper_test

// ---- bench/dim_checker.sv ----
`timescale 1ns/1ps
module dim_checker (
    input wire clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire manual_mode,
    input wire fieldbus_control,
    input wire [15:0] general_status_word,
    input wire start_enable,
    input wire forward_rotation,
    input wire reverse_rotation,
    input wire [2:0] output_relay,
    input wire [15:0] counter_display_value
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
sequence wait_state;
    psel && penable && !pready;
endsequence
sequence one_pulse;
    pready ##1 !pready;
endsequence
////////////////////////////////////////////////////////////////
a_apb_one_wait: assert property (wait_state |=> one_pulse)
    else $error("ready not after one wait state");
a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
a_fwd_alone: assert property (forward_rotation |-> start_enable && !reverse_rotation)
    else $error("forward without start");
a_rev_pair: assert property (reverse_rotation |-> start_enable && !forward_rotation)
    else $error("reverse without start");
a_no_bare_start: assert property (start_enable |-> forward_rotation ^ reverse_rotation)
    else $error("start with no direction");
a_manual_leaves_bus: assert property (fieldbus_control == !manual_mode)
    else $error("manual and fieldbus overlap");
a_status_word_bits: assert property ((general_status_word & 16'hf7ff) == 16'h0000)
    else $error("stray status word bit");
// a wrap to zero may hit a zero compare, so only a reset drop is judged
a_reset_drops_relays: assert property ($changed(counter_display_value) &&
    counter_display_value == 16'h0000 && $past(counter_display_value) != 16'hffff
    |-> output_relay == 3'h0) else $error("relay kept over counter reset");
a_count_single_step: assert property ($changed(counter_display_value) |->
    counter_display_value == $past(counter_display_value) + 16'h0001 ||
    counter_display_value == 16'h0000) else $error("counter jumped");
endmodule // dim_checker
bind dim_top dim_checker dim_checker_inst (.clk, .rstn, .psel, .penable, .pready, .pslverr,
    .manual_mode, .fieldbus_control, .general_status_word, .start_enable, .forward_rotation,
    .reverse_rotation, .output_relay, .counter_display_value);

// ---- bench/dim_switches.sv ----
`timescale 1ns/1ps
module dim_switches (
    input wire clk,
    input wire [5:0] press,
    input wire [5:0] nc_wired,
    output reg [5:0] contact
);
// a pressed n/c contact opens; no bounce modelled, so edges are clean
initial contact = 6'h00;
always @(posedge clk) begin
    contact <= press ^ nc_wired;
end
endmodule // dim_switches

// ---- core/dim_consts.vh ----
`ifndef DIM_CONSTS_VH
`define DIM_CONSTS_VH
// register byte offsets
`define DIM_OFS_CTRL 8'h00
`define DIM_OFS_POL 8'h04
`define DIM_OFS_ASSIGN 8'h08
`define DIM_OFS_CMP1 8'h0c
`define DIM_OFS_CMP2 8'h10
`define DIM_OFS_OUTSEL 8'h14
`define DIM_OFS_COUNT 8'h18
`define DIM_OFS_FUNC 8'h1c
`define DIM_OFS_GSW 8'h20
`define DIM_OFS_IRQ_STAT 8'h24
`define DIM_OFS_IRQ_MASK 8'h28
// reset values
`define DIM_RST_CTRL 3'h0
`define DIM_RST_POL 6'h00
`define DIM_RST_ASSIGN 24'h000000
`define DIM_RST_CMP 16'h0000
`define DIM_RST_OUTSEL 15'h0000
`define DIM_RST_IRQ 4'h0
// terminal assignment fields, 3 bits each, 0 = unassigned
`define DIM_AS_PAUSE 0
`define DIM_AS_CNT_SRC 3
`define DIM_AS_CNT_RST 6
`define DIM_AS_REMOTE 9
`define DIM_AS_SPEED 12
`define DIM_AS_PSET 15
`define DIM_AS_FBUS 18
`define DIM_AS_MANUAL 21
// output selector fields, 5 bits each
`define DIM_OS_W 5
`define DIM_OS_CODE_CMP1 5'h14
`define DIM_OS_CODE_CMP2 5'h15
// start/stop logic mode with forward / reverse pair
`define DIM_SS_FWD_REV 3'h1
// general status word bit driven by the fieldbus remote input
`define DIM_GSW_FBUS_BIT 11
// interrupt status bits
`define DIM_IRQ_CMP1 0
`define DIM_IRQ_CMP2 1
`define DIM_IRQ_CNT_RST 2
`define DIM_IRQ_COUNT 3
`endif

// ---- core/dim_counter.v ----
`timescale 1ns/1ps
`include "dim_consts.vh"
module dim_counter (
    input wire clk,
    input wire rstn,
    input wire inc,
    input wire clr,
    input wire [15:0] cmp1,
    input wire [15:0] cmp2,
    output reg [15:0] count,
    output reg hit1,
    output reg hit2,
    output wire hit1_pulse,
    output wire hit2_pulse
);
////////////////////////////////////////////////////////////////////////////////
wire [15:0] next_count;
assign next_count = count + 16'h0001;
// reaching a value means stepping onto it, so the reset value fires only on a wrap from ffff
assign hit1_pulse = inc & ~clr & (next_count == cmp1);
assign hit2_pulse = inc & ~clr & (next_count == cmp2);
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        count <= `DIM_RST_CMP;
        hit1 <= 1'b0;
        hit2 <= 1'b0;
    end else if (clr) begin
        // reset held wins over counting
        count <= 16'h0000;
        hit1 <= 1'b0;
        hit2 <= 1'b0;
    end else if (inc) begin
        count <= next_count;
        hit1 <= hit1 | hit1_pulse;
        hit2 <= hit2 | hit2_pulse;
    end
end
endmodule // dim_counter

// ---- core/dim_polarity.v ----
`timescale 1ns/1ps
module dim_polarity (
    input wire clk,
    input wire rstn,
    input wire [5:0] raw,
    input wire [5:0] pol,
    output reg [5:0] level,
    output wire [5:0] rise
);
////////////////////////////////////////////////////////////////////////////////
reg [5:0] prev;
genvar i;
generate
    for (i = 0; i < 6; i = i + 1) begin : g_in
        always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                level[i] <= 1'b0;
                prev[i] <= 1'b0;
            end else begin
                level[i] <= raw[i] ^ pol[i];
                prev[i] <= level[i];
            end
        end
        // one pulse per rising transition, not per cycle held
        assign rise[i] = level[i] & ~prev[i];
    end
endgenerate
endmodule // dim_polarity

// ---- core/dim_top.v ----
`timescale 1ns/1ps
`include "dim_consts.vh"
// Function
// - pause input active holds sequence program between steps until released
// - event counter increments once per activation of selected counter source input
// - counter reset input clears counter and drops outputs coded 20 or 21
// - first 16-bit compare value, default 0, triggers outputs coded 20
// - second 16-bit compare value, default 0, triggers outputs coded 21
// - secondary remote input selects secondary control level, local/remote changeover
// - secondary speed reference input switches setpoint to second analog source
// - parameter set input active selects alternate parameter group values
// - fieldbus remote input copied into bit 11 of general status word
// - per-input polarity: 0 normally open, 1 normally closed inverts level
// - manual mode input leaves fieldbus control for manual level and source
// - selector 1: run only with input one, alone gives forward start
// - selector 1: inputs one and two together give reverse start
// - selector 1: input two without input one gives no start
module dim_top (
    input wire clk,
    input wire rstn,
    input wire [5:0] input_terminals_all,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    output reg program_pause,
    output reg local_remote_changeover,
    output reg analog_setpoint_second,
    output reg alternate_parameter_set,
    output reg manual_mode,
    output reg fieldbus_control,
    output reg [15:0] general_status_word,
    output reg start_enable,
    output reg forward_rotation,
    output reg reverse_rotation,
    output reg [2:0] output_relay,
    output reg [15:0] counter_display_value
);
////////////////////////////////////////////////////////////////////////////////
// registers
reg [2:0] start_stop_logic_selector;
reg [5:0] input_polarity_setting;
reg [23:0] assign_map;
reg [15:0] counter_compare_one;
reg [15:0] counter_compare_two;
reg [14:0] output_function_selectors;
reg [3:0] irq_stat;
reg [3:0] irq_mask;

wire [5:0] level;
wire [5:0] rise;
wire [15:0] count;
wire hit1;
wire hit2;
wire hit1_pulse;
wire hit2_pulse;

////////////////////////////////////////////////////////////////////////////////
// terminal lookup: code 1..6 picks a terminal, anything else is inactive
function pick;
    input [2:0] code;
    input [5:0] lv;
    begin
        case (code)
            3'h1: pick = lv[0];
            3'h2: pick = lv[1];
            3'h3: pick = lv[2];
            3'h4: pick = lv[3];
            3'h5: pick = lv[4];
            3'h6: pick = lv[5];
            default: pick = 1'b0;
        endcase
    end
endfunction

wire f_pause = pick(assign_map[`DIM_AS_PAUSE +: 3], level);
wire f_cnt_inc = pick(assign_map[`DIM_AS_CNT_SRC +: 3], rise);
wire f_cnt_rst = pick(assign_map[`DIM_AS_CNT_RST +: 3], level);
wire f_cnt_rst_rise = pick(assign_map[`DIM_AS_CNT_RST +: 3], rise);
wire f_remote = pick(assign_map[`DIM_AS_REMOTE +: 3], level);
wire f_speed = pick(assign_map[`DIM_AS_SPEED +: 3], level);
wire f_pset = pick(assign_map[`DIM_AS_PSET +: 3], level);
wire f_fbus = pick(assign_map[`DIM_AS_FBUS +: 3], level);
wire f_manual = pick(assign_map[`DIM_AS_MANUAL +: 3], level);

wire input_terminal_one = level[0];
wire input_terminal_two = level[1];

////////////////////////////////////////////////////////////////////////////////
dim_polarity u_pol (
    .clk(clk),
    .rstn(rstn),
    .raw(input_terminals_all),
    .pol(input_polarity_setting),
    .level(level),
    .rise(rise)
);

dim_counter u_cnt (
    .clk(clk),
    .rstn(rstn),
    .inc(f_cnt_inc),
    .clr(f_cnt_rst),
    .cmp1(counter_compare_one),
    .cmp2(counter_compare_two),
    .count(count),
    .hit1(hit1),
    .hit2(hit2),
    .hit1_pulse(hit1_pulse),
    .hit2_pulse(hit2_pulse)
);

////////////////////////////////////////////////////////////////////////////////
// output relays: only codes 20/21 are owned here, others read low
reg [2:0] next_relay;
integer k;
always @* begin
    next_relay = 3'h0;
    for (k = 0; k < 3; k = k + 1) begin
        case (output_function_selectors[k*`DIM_OS_W +: `DIM_OS_W])
            `DIM_OS_CODE_CMP1: next_relay[k] = hit1;
            `DIM_OS_CODE_CMP2: next_relay[k] = hit2;
            default: next_relay[k] = 1'b0;
        endcase
    end
end

// start/stop logic, other selector values give no enable from this block
wire ss_mode = (start_stop_logic_selector == `DIM_SS_FWD_REV);
wire next_start = ss_mode & input_terminal_one;
wire next_fwd = ss_mode & input_terminal_one & ~input_terminal_two;
wire next_rev = ss_mode & input_terminal_one & input_terminal_two;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        program_pause <= 1'b0;
        local_remote_changeover <= 1'b0;
        analog_setpoint_second <= 1'b0;
        alternate_parameter_set <= 1'b0;
        manual_mode <= 1'b0;
        fieldbus_control <= 1'b1;
        general_status_word <= 16'h0000;
        start_enable <= 1'b0;
        forward_rotation <= 1'b0;
        reverse_rotation <= 1'b0;
        output_relay <= 3'h0;
        counter_display_value <= 16'h0000;
    end else begin
        // sequencer checks this only at step boundaries
        program_pause <= f_pause;
        local_remote_changeover <= f_remote;
        analog_setpoint_second <= f_speed;
        alternate_parameter_set <= f_pset;
        manual_mode <= f_manual;
        fieldbus_control <= ~f_manual;
        general_status_word <= 16'h0000;
        general_status_word[`DIM_GSW_FBUS_BIT] <= f_fbus;
        start_enable <= next_start;
        forward_rotation <= next_fwd;
        reverse_rotation <= next_rev;
        output_relay <= next_relay;
        counter_display_value <= count;
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave, one wait state so read data comes from a flop
wire acc = psel & penable;
wire wr = acc & pwrite & pready;
wire [3:0] irq_set;
assign irq_set[`DIM_IRQ_CMP1] = hit1_pulse;
assign irq_set[`DIM_IRQ_CMP2] = hit2_pulse;
assign irq_set[`DIM_IRQ_CNT_RST] = f_cnt_rst_rise;
assign irq_set[`DIM_IRQ_COUNT] = f_cnt_inc & ~f_cnt_rst;

reg [31:0] next_rdata;
reg next_err;
always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
        `DIM_OFS_CTRL: next_rdata[2:0] = start_stop_logic_selector;
        `DIM_OFS_POL: next_rdata[5:0] = input_polarity_setting;
        `DIM_OFS_ASSIGN: next_rdata[23:0] = assign_map;
        `DIM_OFS_CMP1: next_rdata[15:0] = counter_compare_one;
        `DIM_OFS_CMP2: next_rdata[15:0] = counter_compare_two;
        `DIM_OFS_OUTSEL: next_rdata[14:0] = output_function_selectors;
        `DIM_OFS_COUNT: next_rdata[15:0] = count;
        `DIM_OFS_FUNC: next_rdata = {10'h000, level, 6'h00, next_rev, next_fwd,
            next_start, fieldbus_control, f_manual, f_fbus, f_pset, f_speed,
            f_remote, f_pause};
        `DIM_OFS_GSW: next_rdata[15:0] = general_status_word;
        `DIM_OFS_IRQ_STAT: next_rdata[3:0] = irq_stat;
        `DIM_OFS_IRQ_MASK: next_rdata[3:0] = irq_mask;
        default: next_err = 1'b1;
    endcase
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        pready <= acc & ~pready;
        pslverr <= acc & ~pready & next_err;
        prdata <= (acc & ~pready & ~pwrite) ? next_rdata : 32'h00000000;
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        start_stop_logic_selector <= `DIM_RST_CTRL;
        input_polarity_setting <= `DIM_RST_POL;
        assign_map <= `DIM_RST_ASSIGN;
        counter_compare_one <= `DIM_RST_CMP;
        counter_compare_two <= `DIM_RST_CMP;
        output_function_selectors <= `DIM_RST_OUTSEL;
        irq_mask <= `DIM_RST_IRQ;
    end else if (wr) begin
        case (paddr)
            `DIM_OFS_CTRL: start_stop_logic_selector <= pwdata[2:0];
            `DIM_OFS_POL: input_polarity_setting <= pwdata[5:0];
            `DIM_OFS_ASSIGN: assign_map <= pwdata[23:0];
            `DIM_OFS_CMP1: counter_compare_one <= pwdata[15:0];
            `DIM_OFS_CMP2: counter_compare_two <= pwdata[15:0];
            `DIM_OFS_OUTSEL: output_function_selectors <= pwdata[14:0];
            `DIM_OFS_IRQ_MASK: irq_mask <= pwdata[3:0];
            default: ;
        endcase
    end
end

// sticky status, a new event beats a write-one clear in the same cycle
wire [3:0] irq_clr = (wr && paddr == `DIM_OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0;
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        irq_stat <= `DIM_RST_IRQ;
        irq <= 1'b0;
    end else begin
        irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        irq <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
end
endmodule // dim_top
